// File: io_mux_cfg.svh
// Offsets, reset values, widths and response codes of the line mux block.
`ifndef IO_MUX_CFG_SVH
`define IO_MUX_CFG_SVH

// Number of lines and bus widths.
`define LINE_COUNT     32
`define ADDR_W         8
`define DATA_W         32
`define STRB_W         4

// Register byte offsets.
`define OFF_OWN_EN     8'h00
`define OFF_OWN_DIS    8'h04
`define OFF_OWN_STATE  8'h08
`define OFF_PU_EN      8'h0c
`define OFF_PU_DIS     8'h10
`define OFF_PU_STATE   8'h14
`define OFF_SEL_A      8'h18
`define OFF_SEL_B      8'h1c
`define OFF_SEL_STATE  8'h20
`define OFF_PIN_LEVEL  8'h24
`define OFF_CLK_STATE  8'h28

// Reset values.
`define RST_PU_STATE   32'h0000_0000
`define RST_SEL_STATE  32'h0000_0000
`define RST_PIN_LEVEL  32'h0000_0000
`define RST_OWN_STATE  32'hffff_ffff
`define RST_MUXED      32'hffff_ffff

// Response codes.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// File: io_mux_pkg.sv
// Types shared by the line mux block and its per-line slice.
package io_mux_pkg;

  // Drive of all lines: level and enable, bit n for line n.
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } drive_t;

  // Drive of one line.
  typedef struct packed {
    logic out;
    logic oe;
  } bit_drive_t;

  // Write channel phase.
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_phase_t;

  // Read channel phase.
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_phase_t;

  // Whole state of the block.
  typedef struct packed {
    logic [31:0] own;
    logic [31:0] sel_b;
    logic [31:0] pu_off;
    logic [31:0] pin_level;
    logic        clk_en;
    logic        irq;
    wr_phase_t   wr;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    rd_phase_t   rd;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage

// File: io_line_slice.sv
// One line of the pad output multiplexer.
`timescale 1ns/10ps
module io_line_slice
  import io_mux_pkg::*;
#(
  parameter bit MUXED = 1'b1
) (
  input  wire logic       own,
  input  wire logic       sel_b,
  input  wire bit_drive_t gpio,
  input  wire bit_drive_t pa,
  input  wire bit_drive_t pb,
  output bit_drive_t      pad
);

  // A line without peripherals is driven by the I/O logic only.
  always_comb begin
    if (!MUXED || own) begin
      pad = gpio;
    end else if (sel_b) begin
      pad = pb;
    end else begin
      pad = pa;
    end
  end

endmodule // io_line_slice

// File: io_line_mux_and_pullup.sv
// Line ownership, peripheral A/B choice and pull-up control with AXI4-Lite access.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "io_mux_cfg.svh"
module io_line_mux_and_pullup
  import io_mux_pkg::*;
#(
  parameter logic [31:0] MUXED_MASK = `RST_MUXED,
  parameter logic [31:0] OWN_RESET  = `RST_OWN_STATE
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] pad_in,
  output drive_t           pad,
  output logic [31:0]      pad_pullup_en,
  input  wire drive_t      gpio,
  input  wire drive_t      periph_a,
  input  wire drive_t      periph_b,
  output logic [31:0]      periph_in,
  input  wire logic        ctrl_clk_en,
  input  wire logic        change_irq_req,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State registers.
  ////////////////////////////////////////////////////////////////////////////

  // The whole block is one state word: one image of it is computed each cycle
  // and one register stage holds it, so no field can miss the common reset.
  state_t state_r;
  state_t state_nxt;

  // Reset image; ownership of unmuxed lines is held at one.
  localparam state_t RESET_STATE = '{
    own:       OWN_RESET | ~MUXED_MASK,
    sel_b:     `RST_SEL_STATE,
    pu_off:    `RST_PU_STATE,
    pin_level: `RST_PIN_LEVEL,
    clk_en:    1'b0,
    irq:       1'b0,
    wr:        WR_COLLECT,
    aw_got:    1'b0,
    w_got:     1'b0,
    waddr:     8'h00,
    wdata:     32'h0000_0000,
    wstrb:     4'h0,
    bresp:     `RESP_OKAY,
    rd:        RD_IDLE,
    rdata:     32'h0000_0000,
    rresp:     `RESP_OKAY
  };

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes.
  ////////////////////////////////////////////////////////////////////////////

  // Address and data are taken once each per write, in either order.
  // A second write is held off until its response has been taken, so the
  // staged address and data are never overwritten before they are applied.
  assign awready = (state_r.wr == WR_COLLECT) && !state_r.aw_got;
  assign wready  = (state_r.wr == WR_COLLECT) && !state_r.w_got;
  assign arready = (state_r.rd == RD_IDLE);

  // Responses come straight from the state registers.
  // The command is applied at the edge that raises the response, so a read
  // that follows the response always sees the new line configuration.
  assign bvalid = (state_r.wr == WR_RESP);
  assign bresp  = state_r.bresp;
  assign rvalid = (state_r.rd == RD_RESP);
  assign rdata  = state_r.rdata;
  assign rresp  = state_r.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode helpers.
  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] wmask;
  logic [31:0] cmd;
  logic [7:0]  waligned;
  logic        wmapped;

  // Byte lanes without a strobe leave their lines alone.
  always_comb begin
    for (int b = 0; b < `STRB_W; b++) begin
      wmask[8*b +: 8] = {8{state_r.wstrb[b]}};
    end
  end

  // Only ones in enabled lanes act on a line.
  assign cmd      = state_r.wdata & wmask;
  assign waligned = {state_r.waddr[7:2], 2'b00};

  // Every word from the first to the last offset is a register.
  always_comb begin
    case (waligned)
      `OFF_OWN_EN,
      `OFF_OWN_DIS,
      `OFF_OWN_STATE,
      `OFF_PU_EN,
      `OFF_PU_DIS,
      `OFF_PU_STATE,
      `OFF_SEL_A,
      `OFF_SEL_B,
      `OFF_SEL_STATE,
      `OFF_PIN_LEVEL,
      `OFF_CLK_STATE: begin
        wmapped = 1'b1;
      end
      default: begin
        wmapped = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode.
  ////////////////////////////////////////////////////////////////////////////

  logic [31:0] rd_word;
  logic [1:0]  rd_code;
  logic [7:0]  raligned;

  // The word is chosen while the address is offered, so the answer carries
  // the state as it stood at the edge that took the address.
  assign raligned = {araddr[7:2], 2'b00};

  // Status registers show state; command registers read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_code = `RESP_OKAY;
    case (raligned)
      `OFF_OWN_STATE: begin
        rd_word = state_r.own;
      end
      `OFF_PU_STATE: begin
        rd_word = state_r.pu_off;
      end
      `OFF_SEL_STATE: begin
        rd_word = state_r.sel_b;
      end
      `OFF_PIN_LEVEL: begin
        rd_word = state_r.pin_level;
      end
      `OFF_CLK_STATE: begin
        rd_word = {31'h0000_0000, state_r.clk_en};
      end
      `OFF_OWN_EN,
      `OFF_OWN_DIS,
      `OFF_PU_EN,
      `OFF_PU_DIS,
      `OFF_SEL_A,
      `OFF_SEL_B: begin
        rd_word = 32'h0000_0000;
      end
      default: begin
        rd_code = `RESP_SLVERR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  ////////////////////////////////////////////////////////////////////////////

  // Register writes never look at the gated clock enable.
  always_comb begin
    state_nxt = state_r;

    // Gated clock enable follows the power manager one edge late.
    // Registering it keeps the sampler and the interrupt path on one common
    // view of the enable in every cycle.
    state_nxt.clk_en = ctrl_clk_en;

    // Pin levels are sampled only while the gated clock runs.
    // With the clock off the last sample is kept, so software reads the
    // levels that stood when the clock stopped.
    if (state_r.clk_en) begin
      state_nxt.pin_level = pad_in;
    end

    // Interrupt passes only while the gated clock runs.
    state_nxt.irq = state_r.clk_en & change_irq_req;

    // Write channel.
    // Address and data may arrive in either order; each is kept once taken.
    case (state_r.wr)
      WR_COLLECT: begin
        if (awvalid && awready) begin
          state_nxt.aw_got = 1'b1;
          state_nxt.waddr  = awaddr;
        end
        if (wvalid && wready) begin
          state_nxt.w_got = 1'b1;
          state_nxt.wdata = wdata;
          state_nxt.wstrb = wstrb;
        end
        if (state_r.aw_got && state_r.w_got) begin
          state_nxt.aw_got = 1'b0;
          state_nxt.w_got  = 1'b0;
          state_nxt.wr     = WR_RESP;
          state_nxt.bresp  = wmapped ? `RESP_OKAY : `RESP_SLVERR;
          // Status words and unmapped words leave every line alone.
          case (waligned)
            `OFF_OWN_EN: begin
              state_nxt.own = state_r.own | cmd;
            end
            `OFF_OWN_DIS: begin
              state_nxt.own = state_r.own & ~(cmd & MUXED_MASK);
            end
            `OFF_PU_EN: begin
              state_nxt.pu_off = state_r.pu_off & ~cmd;
            end
            `OFF_PU_DIS: begin
              state_nxt.pu_off = state_r.pu_off | cmd;
            end
            `OFF_SEL_A: begin
              state_nxt.sel_b = state_r.sel_b & ~cmd;
            end
            `OFF_SEL_B: begin
              state_nxt.sel_b = state_r.sel_b | cmd;
            end
            default: begin
              state_nxt.own = state_r.own;
            end
          endcase
        end
      end
      WR_RESP: begin
        if (bready) begin
          state_nxt.wr = WR_COLLECT;
        end
      end
      default: begin
        state_nxt.wr = WR_COLLECT;
      end
    endcase

    // Read channel.
    // Only one read is in flight; arready stays low until the answer is taken.
    case (state_r.rd)
      RD_IDLE: begin
        if (arvalid) begin
          state_nxt.rd    = RD_RESP;
          state_nxt.rdata = rd_word;
          state_nxt.rresp = rd_code;
        end
      end
      RD_RESP: begin
        if (rready) begin
          state_nxt.rd = RD_IDLE;
        end
      end
      default: begin
        state_nxt.rd = RD_IDLE;
      end
    endcase
  end

  // One register stage for the whole state, synchronous reset.
  // The bus and the pads settle to the reset image at the first reset edge,
  // and no field is left out of the common reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= RESET_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad side.
  ////////////////////////////////////////////////////////////////////////////

  // Pull-up is on where the disabled bit is clear.
  // It follows the stored bit directly, whatever owns the line.
  assign pad_pullup_en = ~state_r.pu_off;

  // Pin levels reach peripherals and interrupt inputs untouched.
  // Nothing here gates them, so external interrupt lines work even on a
  // line that is not assigned to them.
  assign periph_in = pad_in;

  // Gated interrupt request.
  assign irq = state_r.irq;

  // One output multiplexer per line, same bit position everywhere.
  // A line without peripherals ignores its ownership and choice bits inside
  // the slice too, so a wrong reset image cannot hand it to a peripheral.
  for (genvar i = 0; i < `LINE_COUNT; i++) begin : g_line
    bit_drive_t line_pad;

    io_line_slice #(
      .MUXED (MUXED_MASK[i])
    ) i_io_line_slice (
      .own   (state_r.own[i]),
      .sel_b (state_r.sel_b[i]),
      .gpio  (bit_drive_t'({gpio.out[i], gpio.oe[i]})),
      .pa    (bit_drive_t'({periph_a.out[i], periph_a.oe[i]})),
      .pb    (bit_drive_t'({periph_b.out[i], periph_b.oe[i]})),
      .pad   (line_pad)
    );

    assign pad.out[i] = line_pad.out;
    assign pad.oe[i]  = line_pad.oe;
  end

endmodule // io_line_mux_and_pullup

// File: io_line_mux_and_pullup_assertions.sv
// Checker of bus handshakes, pad steering, pull-ups and gated-clock behaviour.
`timescale 1ns/10ps
module io_mux_checker
  import io_mux_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] pad_in,
  input wire logic [31:0] periph_in,
  input wire drive_t      pad,
  input wire logic [31:0] pad_pullup_en,
  input wire drive_t      gpio,
  input wire drive_t      periph_a,
  input wire drive_t      periph_b,
  input wire logic        ctrl_clk_en,
  input wire logic        change_irq_req,
  input wire logic        irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // A write is taken whole, then one quiet cycle passes before the answer.
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_b_late;
    !bvalid ##1 bvalid;
  endsequence

  // Answers hold until taken; pads and pull-ups move only on a committed write.
  chk_b_timing: assert property (s_wr_taken |=> s_b_late) else $error("write answer off time");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_r_first: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  chk_inputs_through: assert property (periph_in == pad_in)
    else $error("peripheral input differs from pin");
  chk_irq_gated: assert property ($past(aresetn, 2) |->
    irq == ($past(change_irq_req) && $past(ctrl_clk_en, 2)))
    else $error("interrupt not gated by clock enable");
  chk_pad_source: assert property (
    ((pad ^ gpio) & (pad ^ periph_a) & (pad ^ periph_b)) == '0)
    else $error("pad drive from no source");
  chk_pad_quiet: assert property (!$rose(bvalid) && $stable(gpio) && $stable(periph_a)
    && $stable(periph_b) |-> $stable(pad))
    else $error("pad moved without a write");
  chk_pull_quiet: assert property (!$rose(bvalid) |-> $stable(pad_pullup_en))
    else $error("pull-up moved without a write");
  chk_reset_state: assert property ($rose(aresetn) |->
    pad_pullup_en == '1 && !irq && !bvalid && !rvalid)
    else $error("bad state after reset");
endmodule // io_mux_checker

bind io_line_mux_and_pullup io_mux_checker i_io_mux_checker (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .pad_in, .periph_in, .pad,
  .pad_pullup_en, .gpio, .periph_a, .periph_b, .ctrl_clk_en, .change_irq_req, .irq
);

// File: io_pad_world.sv
// Pads and outside devices: the level each pin settles to.
`timescale 1ns/10ps
module io_pad_world
  import io_mux_pkg::*;
(
  input  wire logic        aclk,
  input  wire drive_t      pad,
  input  wire logic [31:0] pad_pullup_en,
  output logic [31:0]      pad_in
);
  logic [31:0] last_r = 32'h0;

  // Remember the last level driven on each pin.
  always @(posedge aclk) begin
    last_r <= (pad.oe & pad.out) | (~pad.oe & last_r);
  end

  // A released pin floats to the inverse of its last level unless the pull-up holds it.
  always_comb begin
    pad_in = (pad.oe & pad.out) | (~pad.oe & (pad_pullup_en | ~last_r));
  end
endmodule // io_pad_world

// File: io_line_mux_and_pullup_tb.sv
// Self-checking bench of the line mux and pull-up block.
`timescale 1ns/10ps
`include "io_mux_cfg.svh"
module io_line_mux_and_pullup_tb;
  import io_mux_pkg::*;
  localparam logic [31:0] MUXED = 32'hffff_fff0;
  localparam logic [31:0] OWN_RST = 32'h0000_ff00;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ctrl_clk_en = 1'b0, change_irq_req = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, a;
  logic [31:0] wdata = 32'h0, own_m, sel_m, pu_m, lv, d, m;
  logic [3:0]  wstrb = 4'h0, s;
  drive_t      gpio = '0, periph_a = '0, periph_b = '0, pad, e;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, pad_in, pad_pullup_en, periph_in;
  int          err_total = 0, n_checks = 0, cycles = 0, seed = 80826, k, lag = 0;

  // Clock of 100 MHz.
  always #5 aclk = ~aclk;

  io_line_mux_and_pullup #(.MUXED_MASK(MUXED), .OWN_RESET(OWN_RST)) i_io_line_mux_and_pullup (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .pad_in, .pad, .pad_pullup_en, .gpio, .periph_a, .periph_b, .periph_in,
    .ctrl_clk_en, .change_irq_req, .irq
  );
  io_pad_world i_io_pad_world (.aclk, .pad, .pad_pullup_en, .pad_in);

  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang ends the run as a mismatch.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      err_total++;
    end
  endtask

  // Byte-lane mask of a write: lines in lanes without a strobe stay put.
  function automatic logic [31:0] exp_mask(input logic [3:0] st);
    exp_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  // Pad drive that the ownership and choice models call for, line by line.
  function automatic drive_t exp_pad(input logic [31:0] own, input logic [31:0] sel);
    logic [63:0] o2, s2;
    o2 = {own, own};
    s2 = {sel, sel};
    exp_pad = (o2 & gpio) | (~o2 & ((s2 & periph_b) | (~s2 & periph_a)));
  endfunction

  // Bus write: address and data offered together, each released once taken.
  // The response ready is raised lag cycles late, never after the answer rises, so no held write answer is seen.
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
    int w = 0;
    bit got = 1'b0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    do begin
      @(posedge aclk);
      w++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        r = bresp;
        got = 1'b1;
      end
      if (w == lag) bready <= 1'b1;
    end while (!got);
  endtask

  task automatic rd(input logic [7:0] ad);
    int w = 0;
    bit got = 1'b0;
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do begin
      @(posedge aclk);
      w++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        got = 1'b1;
      end
      if (w == lag) rready <= 1'b1;
    end while (!got);
  endtask

  // Compare the ownership, pull-up and choice status registers and the pads with the bench's own model.
  task automatic check_all();
    e = exp_pad(own_m, sel_m);
    rd(`OFF_OWN_STATE);
    chk(d, own_m);
    rd(`OFF_PU_STATE);
    chk(d, pu_m);
    rd(`OFF_SEL_STATE);
    chk(d, sel_m);
    chk(pad_pullup_en, ~pu_m);
    chk(pad.out, e.out);
    chk(pad.oe, e.oe);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    own_m = OWN_RST | ~MUXED;
    sel_m = 32'h0;
    pu_m = 32'h0;
    check_all();
    rd(`OFF_CLK_STATE);
    chk(d, 32'h0);
  endtask

  initial begin
    do_reset();
    // Random commands and strobes with the gated clock off.
    for (int i = 0; i < 40; i++) begin
      k = {$random(seed)} % 6;
      d = $random(seed);
      s = (i < 6) ? 4'hf : 4'($random(seed));
      m = d & exp_mask(s);
      lag = {$random(seed)} % 3;
      gpio <= {$random(seed), $random(seed)};
      periph_a <= {$random(seed), $random(seed)};
      periph_b <= {$random(seed), $random(seed)};
      case (k)
        0: a = `OFF_OWN_EN;
        1: a = `OFF_OWN_DIS;
        2: a = `OFF_PU_EN;
        3: a = `OFF_PU_DIS;
        4: a = `OFF_SEL_A;
        default: a = `OFF_SEL_B;
      endcase
      if (k == 0) own_m = own_m | m;
      if (k == 1) own_m = (own_m & ~m) | ~MUXED;
      if (k == 2) pu_m = pu_m & ~m;
      if (k == 3) pu_m = pu_m | m;
      if (k == 4) sel_m = sel_m & ~m;
      if (k == 5) sel_m = sel_m | m;
      wr(a, d, s);
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
      rd(a);
      chk(d, 32'h0);
      check_all();
    end
    // An unmapped word is refused and changes nothing.
    wr(8'h2c, 32'hffff_ffff, 4'hf);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    rd(8'h2c);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    check_all();
    // A status word takes a write with OKAY and keeps its state.
    wr(`OFF_OWN_STATE, 32'h5555_aaaa, 4'hf);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    check_all();
    // Hand line 5 to peripheral B: choice first, then ownership disable.
    wr(`OFF_SEL_B, 32'h0000_0020, 4'hf);
    wr(`OFF_OWN_DIS, 32'h0000_0020, 4'hf);
    sel_m = sel_m | 32'h0000_0020;
    own_m = own_m & ~32'h0000_0020;
    check_all();
    // Interrupt and pin sampling only with the gated clock on.
    change_irq_req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    ctrl_clk_en <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`OFF_CLK_STATE);
    chk(d, 32'h1);
    rd(`OFF_PIN_LEVEL);
    chk(d, pad_in);
    chk(periph_in, pad_in);
    ctrl_clk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    lv = pad_in;
    gpio <= ~gpio;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(`OFF_PIN_LEVEL);
    chk(d, lv);
    do_reset();
    results();
  end
endmodule // io_line_mux_and_pullup_tb
